// *** core/icr_pkg.sv ***
// Package of register map, fields, commands and timing for the control bank
package icr_pkg;
  // ----------------------------------------------------------------------
  // Register byte addresses (even = low byte, odd = high byte)
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_FLASH_WRITE_COUNT = 6'h00;
  localparam logic [5:0] ADDR_X_RATE_BIAS_TRIM = 6'h1A;
  localparam logic [5:0] ADDR_Y_RATE_BIAS_TRIM = 6'h1C;
  localparam logic [5:0] ADDR_Z_RATE_BIAS_TRIM = 6'h1E;
  localparam logic [5:0] ADDR_X_ACCEL_BIAS_TRIM = 6'h20;
  localparam logic [5:0] ADDR_Y_ACCEL_BIAS_TRIM = 6'h22;
  localparam logic [5:0] ADDR_Z_ACCEL_BIAS_TRIM = 6'h24;
  localparam logic [5:0] ADDR_ALARM_ONE_THRESHOLD = 6'h26;
  localparam logic [5:0] ADDR_ALARM_TWO_THRESHOLD = 6'h28;
  localparam logic [5:0] ADDR_ALARM_ONE_PERIOD = 6'h2A;
  localparam logic [5:0] ADDR_ALARM_TWO_PERIOD = 6'h2C;
  localparam logic [5:0] ADDR_ALARM_SETUP = 6'h2E;
  localparam logic [5:0] ADDR_AUX_OUTPUT_LEVEL = 6'h30;
  localparam logic [5:0] ADDR_AUX_DIGITAL_IO_SETUP = 6'h32;
  localparam logic [5:0] ADDR_MISC_SETUP = 6'h34;
  localparam logic [5:0] ADDR_SAMPLE_PERIOD_SETUP = 6'h36;
  localparam logic [5:0] ADDR_RANGE_AND_FILTER_SETUP = 6'h38;
  localparam logic [5:0] ADDR_SLEEP_SETUP = 6'h3A;
  localparam logic [5:0] ADDR_SYSTEM_CONDITION = 6'h3C;
  localparam logic [5:0] ADDR_GLOBAL_TRIGGER = 6'h3E;
  // ----------------------------------------------------------------------
  // Word slots: word index = byte address / 2
  // ----------------------------------------------------------------------
  localparam int NUM_WORDS = 32;
  localparam logic [4:0] IDX_FIRST_TRIM = 5'h0D;
  localparam logic [4:0] IDX_FIRST_ACCEL = 5'h10;
  localparam logic [4:0] IDX_LAST_TRIM = 5'h12;
  localparam logic [4:0] IDX_FIRST_NV = 5'h0D;
  localparam logic [4:0] IDX_LAST_NV = 5'h1C;
  // ----------------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------------
  localparam int RATE_TRIM_MSB = 12;
  localparam int ACCEL_TRIM_MSB = 11;
  localparam int MISC_RATE_COMP_BIT = 7;
  localparam int MISC_ORIGIN_ALIGN_BIT = 6;
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] MISC_NV_MASK = 16'h00FF;
  // Global trigger bits
  localparam int CMD_AUTO_NULL = 0;
  localparam int CMD_FACTORY_RESTORE = 1;
  localparam int CMD_DAC_LATCH = 2;
  localparam int CMD_FLASH_UPDATE = 3;
  localparam int CMD_PRECISION_NULL = 4;
  localparam int CMD_SOFT_RESET = 7;
  // ----------------------------------------------------------------------
  // Timing (50 MHz clock)
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ = 64'd50000000;
  localparam longint FLASH_UPDATE_MS = 64'd100;
  localparam longint PRECISION_NULL_S = 64'd30;
  localparam longint FLASH_UPDATE_CYC = FLASH_UPDATE_MS * CLK_HZ / 64'd1000;
  localparam longint PRECISION_NULL_CYC = PRECISION_NULL_S * CLK_HZ;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] data;
  } icr_req_t;
  typedef struct packed {
    logic [12:0] x;
    logic [12:0] y;
    logic [12:0] z;
  } icr_rate_t;
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } icr_accel_t;
  typedef enum logic [2:0] {
    ST_LOAD, ST_IDLE, ST_PNULL, ST_STORE_SETUP, ST_STORE
  } icr_state_t;
endpackage : icr_pkg

// *** core/icr_word_ram.sv ***
// Small word memory for the nonvolatile flash image
`timescale 1ns/1ps
module icr_word_ram #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [DEPTH];
  // Synchronous write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : icr_word_ram

// *** core/icr_timer.sv ***
// Down counter that pulses when a loaded duration has run out
`timescale 1ns/1ps
module icr_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic [W-1:0] count,
  // Status
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_ff;
  // Load on start, count down to one, pulse done at the end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_ff <= count;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_ff <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - W'(1);
        end
      end
    end
  end
endmodule : icr_timer

// *** core/icr_bank.sv ***
// Control register bank with bias trims, calibration commands and flash image
`timescale 1ns/1ps
module icr_bank
  import icr_pkg::*;
#(
  parameter longint FLASH_CYC = icr_pkg::FLASH_UPDATE_CYC,
  parameter longint PNULL_CYC = icr_pkg::PRECISION_NULL_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Decoded serial frame, one cycle strobe
  input wire icr_pkg::icr_req_t REQ,
  output logic [15:0] RD_DATA,
  // Raw sensor outputs
  input wire icr_pkg::icr_rate_t RATE_RAW,
  input wire icr_pkg::icr_accel_t ACCEL_RAW,
  // Corrected sensor outputs
  output icr_pkg::icr_rate_t RATE_OUT,
  output icr_pkg::icr_accel_t ACCEL_OUT,
  // Feature controls
  output logic RATE_COMP_EN,
  output logic ORIGIN_ALIGN_EN,
  output logic FILTER_FLUSH,
  output logic DAC_LATCH,
  output logic SOFT_RESET,
  output logic CAL_BUSY,
  // Flash image interface
  output logic FLASH_BUSY,
  input wire logic [15:0] SYSTEM_CONDITION
);
  import icr_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  icr_state_t state_ff;
  logic [15:0] regs_ff [NUM_WORDS];
  logic [15:0] wear_ff;
  logic [4:0] ptr_ff;
  logic rd_pend_ff;
  logic [4:0] rd_idx_ff;
  logic [15:0] img_rdata;
  logic img_we;
  logic [15:0] img_wdata;
  logic [4:0] img_raddr;
  logic cmd_wr;
  logic [7:0] cmd;
  logic do_null;
  logic do_restore;
  logic do_flash;
  logic start_pnull;
  logic fl_start;
  logic fl_busy;
  logic fl_done;
  logic pn_busy;
  logic pn_done;
  logic load_valid_ff;

  // Byte write of a word: odd address picks the high byte
  function automatic logic [15:0] put_byte(input logic [15:0] w,
                                           input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction : put_byte

  // Mask applied to the stored image of a word
  function automatic logic [15:0] nv_mask(input logic [4:0] idx);
    if (idx == ADDR_MISC_SETUP[5:1]) begin
      nv_mask = MISC_NV_MASK;
    end else if (idx == ADDR_AUX_OUTPUT_LEVEL[5:1]
                 || idx == ADDR_AUX_DIGITAL_IO_SETUP[5:1]
                 || idx == ADDR_SLEEP_SETUP[5:1]) begin
      nv_mask = 16'h0000;
    end else begin
      nv_mask = 16'hFFFF;
    end
  endfunction : nv_mask

  // Mask of writable bits of a word
  function automatic logic [15:0] wr_mask(input logic [4:0] idx);
    if (idx >= IDX_FIRST_TRIM && idx < IDX_FIRST_ACCEL) begin
      wr_mask = 16'h1FFF;
    end else if (idx >= IDX_FIRST_ACCEL && idx <= IDX_LAST_TRIM) begin
      wr_mask = 16'h0FFF;
    end else if (idx >= IDX_FIRST_TRIM && idx < ADDR_SYSTEM_CONDITION[5:1])
    begin
      wr_mask = 16'hFFFF;
    end else begin
      wr_mask = 16'h0000;
    end
  endfunction : wr_mask

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Command byte acts only as a trigger and is never stored
  assign cmd_wr = REQ.wr && (REQ.addr == ADDR_GLOBAL_TRIGGER);
  assign cmd = cmd_wr ? REQ.data : 8'h00;
  assign do_null = cmd[CMD_AUTO_NULL] && state_ff == ST_IDLE;
  assign do_restore = cmd[CMD_FACTORY_RESTORE] && state_ff == ST_IDLE;
  assign do_flash = cmd[CMD_FLASH_UPDATE] && state_ff == ST_IDLE;
  assign start_pnull = cmd[CMD_PRECISION_NULL] && state_ff == ST_IDLE;
  // Flash store follows explicit update and every calibration command
  assign fl_start = do_flash || do_null || do_restore || pn_done;

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  icr_timer #(.W(32)) u_flash_tmr (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .start(fl_start),
    .count(32'(FLASH_CYC)),
    .busy(fl_busy),
    .done(fl_done)
  );

  // Precision null runs to completion; only reset can stop it
  icr_timer #(.W(32)) u_pnull_tmr (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .start(start_pnull),
    .count(32'(PNULL_CYC)),
    .busy(pn_busy),
    .done(pn_done)
  );

  // ----------------------------------------------------------------------
  // Flash image memory
  // ----------------------------------------------------------------------
  // Image written word by word during store; read during start-up load
  assign img_we = state_ff == ST_STORE;
  assign img_wdata = regs_ff[ptr_ff] & nv_mask(ptr_ff);
  assign img_raddr = ptr_ff;

  icr_word_ram #(.DEPTH(NUM_WORDS), .AW(5)) u_image (
    .clk(SYS_CLK),
    .we(img_we),
    .waddr(ptr_ff),
    .wdata(img_wdata),
    .raddr(img_raddr),
    .rdata(img_rdata)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Start-up load, idle, precision null and store walk
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= ST_LOAD;
      ptr_ff <= IDX_FIRST_NV;
      load_valid_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_LOAD: begin
          load_valid_ff <= 1'b1;
          if (load_valid_ff) begin
            // Read data trails the pointer, so stop one word later
            if (ptr_ff == IDX_LAST_NV + 5'h01) begin
              state_ff <= ST_IDLE;
            end
            ptr_ff <= ptr_ff + 5'h01;
          end
        end
        ST_IDLE: begin
          ptr_ff <= IDX_FIRST_NV;
          if (start_pnull) begin
            state_ff <= ST_PNULL;
          end else if (fl_start) begin
            state_ff <= ST_STORE_SETUP;
          end
        end
        ST_PNULL: begin
          if (pn_done) begin
            state_ff <= ST_STORE_SETUP;
          end
        end
        ST_STORE_SETUP: begin
          state_ff <= ST_STORE;
        end
        ST_STORE: begin
          if (ptr_ff == IDX_LAST_NV) begin
            state_ff <= ST_IDLE;
          end
          ptr_ff <= ptr_ff + 5'h01;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  // Host byte writes, start-up load and calibration loads
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        regs_ff[i] <= WORD_RESET;
      end
    end else begin
      if (state_ff == ST_LOAD && load_valid_ff
          && ptr_ff != IDX_FIRST_NV) begin
        // Image reaches RAM copy at start-up, one word behind the pointer
        regs_ff[ptr_ff - 5'h01] <= img_rdata;
      end
      if (REQ.wr && state_ff != ST_LOAD) begin
        // One frame changes at most one byte of the RAM copy
        regs_ff[REQ.addr[5:1]] <= put_byte(regs_ff[REQ.addr[5:1]],
          REQ.addr[0], REQ.data) & wr_mask(REQ.addr[5:1]);
      end
      if (do_null || pn_done) begin
        // Trim loaded with negated raw output to null it
        regs_ff[ADDR_X_RATE_BIAS_TRIM[5:1]] <= {3'h0, -RATE_RAW.x};
        regs_ff[ADDR_Y_RATE_BIAS_TRIM[5:1]] <= {3'h0, -RATE_RAW.y};
        regs_ff[ADDR_Z_RATE_BIAS_TRIM[5:1]] <= {3'h0, -RATE_RAW.z};
      end
      if (do_restore) begin
        for (int i = IDX_FIRST_TRIM; i <= IDX_LAST_TRIM; i++) begin
          regs_ff[i] <= TRIM_RESET;
        end
      end
    end
  end

  // Flash write counter bumps on each completed store
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wear_ff <= WORD_RESET;
    end else if (fl_done) begin
      wear_ff <= wear_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Either address of a word returns all 16 bits one cycle after the read strobe
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RD_DATA <= WORD_RESET;
    end else if (REQ.rd) begin
      if (REQ.addr[5:1] == ADDR_FLASH_WRITE_COUNT[5:1]) begin
        RD_DATA <= wear_ff;
      end else if (REQ.addr[5:1] == ADDR_SYSTEM_CONDITION[5:1]) begin
        RD_DATA <= SYSTEM_CONDITION;
      end else if (REQ.addr[5:1] == ADDR_GLOBAL_TRIGGER[5:1]) begin
        RD_DATA <= WORD_RESET;
      end else begin
        RD_DATA <= regs_ff[REQ.addr[5:1]];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sensor correction and feature outputs
  // ----------------------------------------------------------------------
  // Trims summed into each sensor path
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RATE_OUT <= '0;
      ACCEL_OUT <= '0;
    end else begin
      RATE_OUT.x <= RATE_RAW.x + regs_ff[ADDR_X_RATE_BIAS_TRIM[5:1]][12:0];
      RATE_OUT.y <= RATE_RAW.y + regs_ff[ADDR_Y_RATE_BIAS_TRIM[5:1]][12:0];
      RATE_OUT.z <= RATE_RAW.z + regs_ff[ADDR_Z_RATE_BIAS_TRIM[5:1]][12:0];
      ACCEL_OUT.x <= ACCEL_RAW.x + regs_ff[ADDR_X_ACCEL_BIAS_TRIM[5:1]][11:0];
      ACCEL_OUT.y <= ACCEL_RAW.y + regs_ff[ADDR_Y_ACCEL_BIAS_TRIM[5:1]][11:0];
      ACCEL_OUT.z <= ACCEL_RAW.z + regs_ff[ADDR_Z_ACCEL_BIAS_TRIM[5:1]][11:0];
    end
  end

  // One-shot command pulses
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      FILTER_FLUSH <= 1'b0;
      DAC_LATCH <= 1'b0;
      SOFT_RESET <= 1'b0;
    end else begin
      FILTER_FLUSH <= do_restore;
      DAC_LATCH <= cmd[CMD_DAC_LATCH];
      SOFT_RESET <= cmd[CMD_SOFT_RESET];
    end
  end

  // Feature enables come straight from their register bits
  assign RATE_COMP_EN =
    regs_ff[ADDR_MISC_SETUP[5:1]][MISC_RATE_COMP_BIT];
  assign ORIGIN_ALIGN_EN =
    regs_ff[ADDR_MISC_SETUP[5:1]][MISC_ORIGIN_ALIGN_BIT];
  assign CAL_BUSY = pn_busy;
  assign FLASH_BUSY = fl_busy || state_ff == ST_STORE;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_restore_clears: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN) do_restore
    |=> regs_ff[IDX_FIRST_TRIM] == TRIM_RESET)
    else $error("trim not cleared by restore");
  a_flush_follows: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN) do_restore |=> FILTER_FLUSH)
    else $error("filter flush missing");
  a_flash_after_null: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN) do_null |=> fl_busy)
    else $error("no flash store after null");
  a_pnull_holds: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN) start_pnull |=> pn_busy [*8])
    else $error("precision null ended early");
  a_rate_comp_bit: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN)
    REQ.wr && REQ.addr == ADDR_MISC_SETUP && state_ff != ST_LOAD
    |=> RATE_COMP_EN == $past(REQ.data[MISC_RATE_COMP_BIT]))
    else $error("rate comp bit not applied");
  a_align_bit: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN)
    REQ.wr && REQ.addr == ADDR_MISC_SETUP && state_ff != ST_LOAD
    |=> ORIGIN_ALIGN_EN == $past(REQ.data[MISC_ORIGIN_ALIGN_BIT]))
    else $error("origin align bit not applied");
  a_wear_counts: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN) fl_done |=> wear_ff == $past(wear_ff) + 16'h0001)
    else $error("flash counter did not advance");
  a_cmd_reads_zero: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN) REQ.rd && REQ.addr[5:1] == ADDR_GLOBAL_TRIGGER[5:1]
    |=> RD_DATA == WORD_RESET)
    else $error("command register not write-only");
  a_misc_image: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN) img_we && ptr_ff == ADDR_MISC_SETUP[5:1]
    |-> img_wdata[15:8] == 8'h00)
    else $error("misc high byte stored");
  a_rate_trim_width: assert property (@(posedge SYS_CLK)
    disable iff (!RSTN) regs_ff[ADDR_X_RATE_BIAS_TRIM[5:1]][15:13] == 3'h0)
    else $error("rate trim upper bits set");
endmodule : icr_bank

// *** sim/icr_host.sv ***
// Host model that drives decoded serial frames into the control bank
`timescale 1ns/1ps
module icr_host
  import icr_pkg::*;
(
  // Clock
  input wire logic SYS_CLK,
  // Decoded frame towards the bank
  output icr_pkg::icr_req_t REQ
);
  import icr_pkg::*;
  // Quiet bus between frames
  initial begin
    REQ = {2'b00, 6'h2A, 8'h55};
  end
  // One frame: write is 1,0,addr,data; read is 0,1,addr
  task automatic put(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    #1;
    REQ = {w, ~w, a, d};
    @(posedge SYS_CLK);
    #1;
    // Released lines show the inverse, not the last value
    REQ = {2'b00, ~a, ~d};
  endtask : put
endmodule : icr_host

// *** sim/tb.sv ***
// Self-checking bench for the control register bank
`timescale 1ns/1ps
module tb;
  import icr_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  icr_req_t req;
  logic [15:0] rd_data;
  icr_rate_t rate_raw, rate_out;
  icr_accel_t accel_raw, accel_out;
  logic rce, oae, ff, dl, sr, cb, fb, rd_q;
  logic [2:0] pv;
  logic [1:0] bv;
  logic [15:0] sc;
  logic [15:0] exp_q[$];
  logic [12:0] ez;
  int bad_count = 0;
  int compares = 0;
  int n;
  // Clock at 50 MHz
  always #10 sys_clk = ~sys_clk;
  icr_bank #(.FLASH_CYC(20), .PNULL_CYC(40)) u_icr_bank (
    .SYS_CLK(sys_clk), .RSTN(rstn), .REQ(req), .RD_DATA(rd_data),
    .RATE_RAW(rate_raw), .ACCEL_RAW(accel_raw), .RATE_OUT(rate_out),
    .ACCEL_OUT(accel_out), .RATE_COMP_EN(rce), .ORIGIN_ALIGN_EN(oae),
    .FILTER_FLUSH(ff), .DAC_LATCH(dl), .SOFT_RESET(sr), .CAL_BUSY(cb),
    .FLASH_BUSY(fb), .SYSTEM_CONDITION(sc));
  icr_host u_host (.SYS_CLK(sys_clk), .REQ(req));
  // Pulse and busy outputs gathered for indexed checks
  assign pv = {sr, dl, ff};
  assign bv = {cb, fb};
  // ----------------------------------------------------------------------
  // Report and compare helpers
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic fail(input string m);
    $display("CHECK FAILED at %0t: %s", $time, m);
    bad_count++;
  endtask : fail
  task automatic chk(input logic a, input logic e, input string m);
    compares++;
    if (a !== e) fail(m);
  endtask : chk
  task automatic chk_word(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e) fail($sformatf("word %h expected %h", a, e));
  endtask : chk_word
  function automatic logic [15:0] ng(input logic [12:0] v);
    ng = {3'b000, 13'(~v + 13'h0001)};
  endfunction : ng
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.put(1'b1, a, d);
  endtask : wr
  // Reads note the expected word for the monitor
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.put(1'b0, a, 8'h00);
  endtask : rd
  // Command pulse: high in the cycle after the write, gone one cycle on
  task automatic pulse(input logic [7:0] c, input int k);
    wr(ADDR_GLOBAL_TRIGGER, c);
    #1;
    chk(pv[k], 1'b1, "pulse missing");
    @(posedge sys_clk);
    #1;
    chk(pv[k], 1'b0, "pulse too long");
  endtask : pulse
  // Bounded wait for a busy level to drop; k 0 flash, 1 calibration
  task automatic wait_low(input int k, input int lim);
    for (n = 0; n < lim && bv[k] !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == lim) begin
      fail("busy never dropped");
      wrap_up();
    end
  endtask : wait_low
  // Monitor: each read word is compared with the oldest note
  always @(posedge sys_clk) rd_q <= req.rd;
  always @(negedge sys_clk) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) fail("read without note");
      else chk_word(rd_data, exp_q.pop_front());
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rate_raw = '0;
    accel_raw = '0;
    // Blank flash image, as shipped
    for (int i = 0; i < NUM_WORDS; i++) u_icr_bank.u_image.mem[i] = 16'h0000;
    void'($urandom(32'h413A677F));
    sc = 16'($urandom());
    repeat (20) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (20) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_X_RATE_BIAS_TRIM + 6'(2 * i), 16'h0000);
    end
    rd(ADDR_GLOBAL_TRIGGER, 16'h0000);
    rd(ADDR_SYSTEM_CONDITION + 6'h01, sc);
    $display("reset values done");
    wr(6'h1E, 8'hF6);
    wr(6'h1F, 8'h1F);
    rd(6'h1E, 16'h1FF6);
    rd(6'h1F, 16'h1FF6);
    wr(6'h1B, 8'hFF);
    rd(6'h1A, 16'h1F00);
    wr(6'h21, 8'hFF);
    wr(6'h20, 8'h5A);
    rd(6'h21, 16'h0F5A);
    rate_raw = icr_rate_t'({$urandom(), $urandom()});
    accel_raw = icr_accel_t'({$urandom(), $urandom()});
    repeat (2) @(negedge sys_clk);
    ez = rate_raw.z + 13'h1FF6;
    chk_word({3'b000, rate_out.z}, {3'b000, ez});
    ez = rate_raw.x + 13'h1F00;
    chk_word({3'b000, rate_out.x}, {3'b000, ez});
    ez = {1'b0, 12'(accel_raw.x + 12'hF5A)};
    chk_word({4'h0, accel_out.x}, {3'b000, ez});
    $display("manual trims done");
    wr(ADDR_MISC_SETUP, 8'h40);
    #1 chk(rce, 1'b0, "rate comp on");
    chk(oae, 1'b1, "align off");
    wr(ADDR_MISC_SETUP, 8'hC0);
    #1 chk(rce, 1'b1, "rate comp off");
    wr(ADDR_MISC_SETUP + 6'h01, 8'h01);
    rd(ADDR_MISC_SETUP, 16'h01C0);
    $display("misc done");
    // Device held still during calibration
    rate_raw = icr_rate_t'({$urandom(), $urandom()});
    wr(ADDR_GLOBAL_TRIGGER, 8'h01);
    #1 chk(fb, 1'b1, "no store after null");
    rd(6'h1A, ng(rate_raw.x));
    rd(6'h1D, ng(rate_raw.y));
    rd(6'h1E, ng(rate_raw.z));
    chk_word({3'b000, rate_out.z}, 16'h0000);
    wait_low(0, 30);
    $display("auto null done");
    pulse(8'h02, 0);
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_X_RATE_BIAS_TRIM + 6'(2 * i), 16'h0000);
    end
    wait_low(0, 30);
    $display("factory restore done");
    rate_raw = icr_rate_t'({$urandom(), $urandom()});
    wr(ADDR_GLOBAL_TRIGGER, 8'h10);
    #1 chk(cb, 1'b1, "precision null idle");
    wr(ADDR_GLOBAL_TRIGGER, 8'h02);
    #1 chk(ff, 1'b0, "restore during null");
    chk(cb, 1'b1, "null stopped early");
    wait_low(1, 60);
    chk(n >= 34, 1'b1, "null too short");
    repeat (2) @(posedge sys_clk);
    wait_low(0, 30);
    rd(6'h1C, ng(rate_raw.y));
    $display("precision null done");
    wr(6'h1A, 8'h33);
    wr(6'h1B, 8'h00);
    wr(ADDR_GLOBAL_TRIGGER, 8'h08);
    #1 chk(fb, 1'b1, "store idle");
    wait_low(0, 30);
    // Null, restore, precision null and explicit update each stored once
    rd(ADDR_FLASH_WRITE_COUNT + 6'h01, 16'h0004);
    wr(6'h1A, 8'h55);
    pulse(8'h04, 1);
    pulse(8'h80, 2);
    rstn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(6'h1A, 16'h0033);
    rd(ADDR_MISC_SETUP, 16'h00C0);
    chk(rce, 1'b1, "feature not reloaded");
    $display("flash image done");
    repeat (3) @(posedge sys_clk);
    wrap_up();
  end
endmodule : tb
